// ===== hdl/wakeup_dispatch_pkg.sv
// Purpose: shared constants for the wake-up and interrupt dispatch block
// Assumes: one clock, synchronous active-high reset
// Notes:   source indices select the per-source decision
package wakeup_dispatch_pkg;

  typedef enum logic [1:0] {
    MODE_SLEEP  = 2'h0,
    MODE_IDLE   = 2'h1,
    MODE_GREEN  = 2'h2,
    MODE_NORMAL = 2'h3
  } power_mode_e;

  typedef enum logic [1:0] {
    OUT_NONE     = 2'h0,
    OUT_NEXT     = 2'h1,
    OUT_VECTOR   = 2'h2
  } resume_e;

  // source indices
  localparam int unsigned SRC_PWM_PERIOD = 0;
  localparam int unsigned SRC_PWM_DUTY   = 1;
  localparam int unsigned SRC_TIMER      = 2;
  localparam int unsigned SRC_COUNTER    = 3;
  localparam int unsigned SRC_WATCH      = 4;
  localparam int unsigned SRC_EXT_PIN    = 5;
  localparam int unsigned SRC_PIN_CHANGE = 6;
  localparam int unsigned SRC_CONVERSION = 7;
  localparam int unsigned NUM_SRC        = 8;

  // sources that may wake from sleep (counter, ext pin, pin change, conversion)
  localparam logic [7:0] SLEEP_WAKE_CAPABLE = 8'hE8;
  // sources with a separate wake enable bit
  localparam logic [7:0] HAS_WAKE_EN        = 8'hE0;
  localparam logic       GIE_RESET          = 1'b0;

endpackage : wakeup_dispatch_pkg

// ===== hdl/wakeup_interrupt_dispatch.sv
// Purpose: decide per event whether it wakes the core and whether it interrupts
// Assumes: events are one-cycle pulses synchronous to ref_clk
// Notes:   outputs are registered, one cycle after the event
//          vector_src lists every source that vectors in that cycle
//          wake-only sources continue even with interrupts globally on, unless another source vectors in that cycle
//          more than eight sources needs wider masks in the package
//
// Summary of operation
// R01 - wake resumes next instruction or vectors by global enable
// R02 - pin wake+irq on: wake both, interrupt running
// R03 - pin wake off, irq on: interrupt only
// R04 - change wake on, irq off: wake, next instruction
// R05 - change wake off, irq on: interrupt only
// R06 - change both on: wake and interrupt
// R07 - conversion wake off, irq on: interrupt only
// R08 - conversion wake on, irq off: wake, next
// R09 - conversion both on: wake and interrupt
// R10 - duty match wakes idle only, interrupts running
// R11 - counter wakes sleep; timers, watch, period idle only
// R12 - both enables off: no wake, no interrupt
`timescale 1ns/10ps
`default_nettype none
module wakeup_interrupt_dispatch
  import wakeup_dispatch_pkg::*;
#(
  parameter int unsigned N_SRC = NUM_SRC
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic [1:0]        power_mode,
  input  wire logic              global_irq_enable_instr,
  input  wire logic              global_irq_disable_instr,
  input  wire logic [N_SRC-1:0]  src_event,
  input  wire logic              pwm_period_match_irq_en,
  input  wire logic              pwm_duty_match_irq_en,
  input  wire logic              timer_counter_irq_en,
  input  wire logic              watch_timer_irq_en,
  input  wire logic              ext_pin_wake_en,
  input  wire logic              ext_pin_irq_en,
  input  wire logic              pin_change_wake_en,
  input  wire logic              pin_change_irq_en,
  input  wire logic              conversion_wake_en,
  input  wire logic              conversion_irq_en,
  output var  logic              global_irq_en,
  output var  logic              wake_req,
  output var  logic              resume_next,
  output var  logic              irq_req,
  output var  logic              vector_req,
  output var  logic [N_SRC-1:0]  vector_src
);

  logic              gie_q;
  logic              wake_q;
  logic              next_q;
  logic              irq_q;
  logic              vec_q;
  logic [N_SRC-1:0]  vsrc_q;
  logic [N_SRC-1:0]  irq_en;
  logic [N_SRC-1:0]  wake_en;
  logic [N_SRC-1:0]  wake_hit;
  logic [N_SRC-1:0]  irq_hit;
  logic              low_power;
  logic              any_wake;
  logic              any_irq;
  logic              gie_d;
  logic              in_sleep;
  logic              in_idle;
  logic [N_SRC-1:0]  wake_vec_hit;
  logic              any_wake_vec;

  // mode decodes shared by the wake and interrupt paths
  function automatic logic is_sleep_mode(input logic [1:0] mode);
    is_sleep_mode = (mode == MODE_SLEEP);
  endfunction : is_sleep_mode

  function automatic logic is_idle_mode(input logic [1:0] mode);
    is_idle_mode = (mode == MODE_IDLE);
  endfunction : is_idle_mode

  function automatic logic is_low_power_mode(input logic [1:0] mode);
    is_low_power_mode = is_sleep_mode(mode) || is_idle_mode(mode);
  endfunction : is_low_power_mode

  // wake for a source without a wake bit: its interrupt enable gates it
  function automatic logic irq_gated_wake(
    input logic ev,
    input logic en,
    input logic sleep_ok,
    input logic sleep_m,
    input logic idle_m
  );
    irq_gated_wake = ev && en && (idle_m || (sleep_m && sleep_ok));
  endfunction : irq_gated_wake

  // wake for a source with a wake bit of its own; sleep and idle alike
  function automatic logic own_bit_wake(
    input logic ev,
    input logic en,
    input logic low_m
  );
    own_bit_wake = ev && en && low_m;
  endfunction : own_bit_wake

  // enable vectors; timer and counter share one interrupt enable
  always_comb begin
    irq_en                 = '0;
    irq_en[SRC_PWM_PERIOD] = pwm_period_match_irq_en;
    irq_en[SRC_PWM_DUTY]   = pwm_duty_match_irq_en;
    irq_en[SRC_TIMER]      = timer_counter_irq_en;
    irq_en[SRC_COUNTER]    = timer_counter_irq_en;
    irq_en[SRC_WATCH]      = watch_timer_irq_en;
    irq_en[SRC_EXT_PIN]    = ext_pin_irq_en;
    irq_en[SRC_PIN_CHANGE] = pin_change_irq_en;
    irq_en[SRC_CONVERSION] = conversion_irq_en;
  end

  // only three sources carry a wake bit of their own
  always_comb begin
    wake_en                 = '0;
    wake_en[SRC_EXT_PIN]    = ext_pin_wake_en;
    wake_en[SRC_PIN_CHANGE] = pin_change_wake_en;
    wake_en[SRC_CONVERSION] = conversion_wake_en;
  end

  assign in_sleep  = is_sleep_mode(power_mode);
  assign in_idle   = is_idle_mode(power_mode);
  assign low_power = is_low_power_mode(power_mode);

  // per-source wake and interrupt decisions
  genvar g;
  generate
    for (g = 0; g < N_SRC; g = g + 1) begin : g_src
      if (HAS_WAKE_EN[g]) begin : g_sep
        // separate wake bit; sleep and idle alike
        assign wake_hit[g] = own_bit_wake(src_event[g], wake_en[g], low_power); // R02 R03 R04 R05 R06 R07 R08 R09 R12
      end else begin : g_irq
        // wake is gated by the interrupt enable; sleep only where capable
        assign wake_hit[g] = irq_gated_wake(src_event[g], irq_en[g], SLEEP_WAKE_CAPABLE[g], in_sleep,
                                            in_idle); // R10 R11 R12
      end
      assign irq_hit[g] = src_event[g] && !low_power && irq_en[g]; // R02 R03 R04 R05 R06 R07 R08 R09 R10 R12
      // a wake that may vector: the source's interrupt enable is on too
      assign wake_vec_hit[g] = wake_hit[g] && irq_en[g]; // R01
    end
  endgenerate

  assign any_wake     = |wake_hit;
  assign any_irq      = |irq_hit;
  assign any_wake_vec = |wake_vec_hit;

  // next global interrupt state; enable wins if both instructions coincide
  always_comb begin
    gie_d = gie_q;
    if (global_irq_enable_instr) begin
      gie_d = 1'b1;
    end else if (global_irq_disable_instr) begin
      gie_d = 1'b0;
    end
  end

  // global interrupt state, disabled out of reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gie_q <= GIE_RESET;
    end else if (clk_en) begin
      gie_q <= gie_d; // R01
    end
  end

  // wake pulse
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_q <= 1'b0;
    end else if (clk_en) begin
      wake_q <= any_wake; // R02 R04 R06 R08 R09 R10 R11
    end
  end

  // resume choice: vectoring needs the irq enable too, so wake-only continues unless another source vectors in that cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      next_q <= 1'b0;
    end else if (clk_en) begin
      next_q <= any_wake && !(gie_q && any_wake_vec); // R01 R04 R08
    end
  end

  // interrupt pulse, running modes only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= any_irq; // R03 R05 R07
    end
  end

  // vector request; gie as it stood before the event, so a same-cycle enable waits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vec_q <= 1'b0;
    end else if (clk_en) begin
      vec_q <= gie_q && (any_irq || any_wake_vec); // R01
    end
  end

  // vector sources, every one that vectors in this cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vsrc_q <= '0;
    end else if (clk_en) begin
      vsrc_q <= gie_q ? (wake_vec_hit | irq_hit) : '0; // R01
    end
  end

  assign global_irq_en = gie_q;
  assign wake_req      = wake_q;
  assign resume_next   = next_q;
  assign irq_req       = irq_q;
  assign vector_req    = vec_q;
  assign vector_src    = vsrc_q;

endmodule : wakeup_interrupt_dispatch
`default_nettype wire

// ===== verif/wakeup_src_model.sv
// Purpose: event source side, one pulse per pick
// Assumes: pick 0 to 7 fires one source, 15 fires all, others none
// Notes: none
`timescale 1ns/10ps
`default_nettype none
module wakeup_src_model (
  input  wire logic       ref_clk,
  input  wire logic [3:0] pick,
  output var  logic [7:0] src_event
);
  // all eight at once shows several sources merging into one answer
  always @(posedge ref_clk) src_event <= pick == 4'hF ? 8'hFF : pick < 4'h8 ? 8'h01 << pick : 8'h00;
endmodule : wakeup_src_model
`default_nettype wire

// ===== verif/wakeup_dispatch_chk.sv
// Purpose: output relations of the dispatch block
// Assumes: sees the dispatch block's ports only
// Notes: bound by name
`timescale 1ns/10ps
`default_nettype none
module wakeup_dispatch_chk (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire logic [1:0] power_mode,
  input wire logic       global_irq_enable_instr,
  input wire logic [7:0] src_event,
  input wire logic       conversion_wake_en,
  input wire logic       conversion_irq_en,
  input wire logic       global_irq_en,
  input wire logic       wake_req,
  input wire logic       resume_next,
  input wire logic       irq_req,
  input wire logic       vector_req,
  input wire logic [7:0] vector_src
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_lp; clk_en && !power_mode[1] |=> !irq_req; endproperty
  a_lp: assert property (p_lp) else $error("irq in low power");
  property p_run; clk_en && power_mode[1] |=> !wake_req; endproperty
  a_run: assert property (p_run) else $error("wake in run");
  property p_slp; clk_en && power_mode == 2'h0 && (src_event & 8'hE8) == 8'h00 |=> !wake_req; endproperty
  a_slp: assert property (p_slp) else $error("sleep wake");
  property p_none; clk_en && src_event == 8'h00 |=> !wake_req && !irq_req; endproperty
  a_none: assert property (p_none) else $error("idle output");
  property p_off;
    clk_en && src_event == 8'h80 && !conversion_wake_en && !conversion_irq_en |=> !wake_req && !irq_req && !vector_req;
  endproperty
  a_off: assert property (p_off) else $error("disabled source answered");
  property p_gie; clk_en && global_irq_enable_instr |=> global_irq_en; endproperty
  a_gie: assert property (p_gie) else $error("gie not set");
  property p_vec; clk_en && !global_irq_en |=> !vector_req; endproperty
  a_vec: assert property (p_vec) else $error("vector without gie");
  property p_vs; vector_req == (vector_src != 8'h00); endproperty
  a_vs: assert property (p_vs) else $error("vector source");
  property p_rn; resume_next |-> wake_req && !vector_req; endproperty
  a_rn: assert property (p_rn) else $error("resume");
  c_wv: cover property (wake_req && vector_req);
  c_rn: cover property (resume_next);
  c_iq: cover property (irq_req && !vector_req);
endmodule : wakeup_dispatch_chk
bind wakeup_interrupt_dispatch wakeup_dispatch_chk u_chk (.*);
`default_nettype wire

// ===== verif/wakeup_interrupt_dispatch_tb_top.sv
// Purpose: random bench with per-cycle reference
// Assumes: pick 15 fires every source at once
// Notes: test 0 fixes the conversion source
`timescale 1ns/10ps
`default_nettype none
module wakeup_interrupt_dispatch_tb_top;
  logic        ref_clk = 0, sys_rst = 1, clk_en = 1, ge = 0, gd = 0, g;
  logic [1:0]  power_mode = 0;
  logic [3:0]  pick = 4'h8;
  logic [9:0]  n = 0;
  logic [11:0] x;
  wire  [7:0]  ev, vs;
  wire         w, rn, iq, vq, gi;
  int          bad_count = 0, checks = 0;
  wakeup_src_model u_src (.ref_clk, .pick, .src_event(ev));
  wakeup_interrupt_dispatch u_dut (.ref_clk, .sys_rst, .clk_en, .power_mode, .global_irq_enable_instr(ge),
    .global_irq_disable_instr(gd), .src_event(ev), .pwm_period_match_irq_en(n[0]), .pwm_duty_match_irq_en(n[1]),
    .timer_counter_irq_en(n[2]), .watch_timer_irq_en(n[3]), .ext_pin_wake_en(n[4]), .ext_pin_irq_en(n[5]),
    .pin_change_wake_en(n[6]), .pin_change_irq_en(n[7]), .conversion_wake_en(n[8]), .conversion_irq_en(n[9]),
    .global_irq_en(gi), .wake_req(w), .resume_next(rn), .irq_req(iq), .vector_req(vq), .vector_src(vs));
  function automatic logic [11:0] f(logic [1:0] m, logic q, logic [7:0] e, logic [9:0] k);
    logic [7:0] ie, wk, v;
    ie = {k[9], k[7], k[5], k[3], k[2], k[2], k[1], k[0]};
    wk = m[1] ? 8'h00 : e & {k[8], k[6], k[4], ie[4:0]} & (m[0] ? 8'hFF : 8'hE8);
    v = e & ie & {8{q}} & (m[1] ? 8'hFF : wk);
    return {|wk, |wk & ~|v, m[1] & |(e & ie), |v, v};
  endfunction : f
  always @(posedge ref_clk)
    if (sys_rst) {x, g} <= 13'h0000;
    else if (clk_en) {x, g} <= {f(power_mode, g, ev, n), ge | (g & !gd)};
  always @(negedge ref_clk) if (!sys_rst) begin
    chk(gi, g);
    chk({w, rn, vq, vs}, {x[11:10], x[8:0]});
    chk(iq, x[9]);
  end
  task automatic chk(logic [10:0] s, logic [10:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial forever #2 ref_clk = ~ref_clk;
  initial begin
    void'($urandom(32'h80a1));
    repeat (4) @(posedge ref_clk);
    sys_rst <= 0;
    for (int t = 0; t < 3; t++) begin
      repeat (2000) begin
        @(posedge ref_clk);
        pick <= t == 0 ? 4'h7 : ($urandom % 16 == 0 ? 4'hF : 4'($urandom % 9));
        power_mode <= 2'($urandom);
        n <= t == 0 ? 10'h3FF : 10'($urandom);
        {ge, gd} <= 2'($urandom);
        clk_en <= t < 2 || $urandom % 2;
      end
      $display("test %0d done", t);
    end
    report_and_stop();
  end
  initial begin
    #40000;
    bad_count++;
    report_and_stop();
  end
endmodule : wakeup_interrupt_dispatch_tb_top
`default_nettype wire
